// ==== usep_map.svh ====
/*
 * Register offsets, field positions, reset values and sizes of the USB
 * endpoint status, FIFO data port and received byte count logic.
 * Assumes it is included by its bare name; it holds definitions only.
 */
`ifndef USEP_MAP_SVH
`define USEP_MAP_SVH


// ----------------------------------------
// Register offsets
// ----------------------------------------
`define USEP_OFS_SELECT 8'hc7
`define USEP_OFS_STATUS 8'hce
`define USEP_OFS_DATA 8'hcf
`define USEP_OFS_CNT_LO 8'he2
`define USEP_OFS_CNT_HI 8'he3

// ----------------------------------------
// Status flag positions
// ----------------------------------------
`define USEP_BIT_DIR 7
`define USEP_BIT_B1 6
`define USEP_BIT_STALL 5
`define USEP_BIT_READY 4
`define USEP_BIT_STALL_SENT_OR_CRC_ERROR 3
`define USEP_BIT_SETUP 2
`define USEP_BIT_B0 1
`define USEP_BIT_CMPL 0

// ----------------------------------------
// Reset values, status after a SETUP, and sizes
// ----------------------------------------
`define USEP_SELECT_RST 4'h0
`define USEP_STATUS_RST 8'h00
`define USEP_STATUS_SETUP_ONLY 8'h04
`define USEP_NUM_EP 6
`define USEP_LAST_EP 4'h5
`define USEP_DEPTH 7'h40

`endif

// ==== usep_pkg.sv ====
/*
 * Types for the endpoint status and FIFO port: types and replies for the endpoint logic, commands and states for the firmware end.
 * Assumes nothing of its surroundings.
 */
package usep_pkg;

	typedef enum logic [1:0] {
		USEP_CONTROL = 2'b00,
		USEP_ISO = 2'b01,
		USEP_BULK = 2'b10,
		USEP_INTR = 2'b11
	} usep_type_e;

	typedef enum logic [1:0] {
		USEP_ACK = 2'b00,
		USEP_NAK = 2'b01,
		USEP_STALL = 2'b10,
		USEP_DATA = 2'b11
	} usep_reply_e;

	typedef enum logic [2:0] {
		USEP_OP_SELECT = 3'b000,
		USEP_OP_STATUS_WR = 3'b001,
		USEP_OP_STATUS_RD = 3'b010,
		USEP_OP_PUSH = 3'b011,
		USEP_OP_POP = 3'b100,
		USEP_OP_COUNT = 3'b101
	} usep_op_e;

	typedef enum logic [2:0] {
		USEP_S_IDLE = 3'b000,
		USEP_S_RD1 = 3'b001,
		USEP_S_RD2 = 3'b010,
		USEP_S_CNT1 = 3'b011,
		USEP_S_CNT2 = 3'b100,
		USEP_S_CNT3 = 3'b101
	} usep_state_e;

endpackage

// ==== usep_if.sv ====
/*
 * Register port between the firmware end and the endpoint logic.
 * Assumes both ends run on the same clock; read data follow a read strobe
 * by one cycle.
 */
`timescale 1ns/1ps
interface usep_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;

	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport fw (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// ==== usep_device.sv ====
/*
 * Endpoint status flags, FIFO data port and received byte count for six
 * endpoints, banks 0 and 1 each 64 bytes deep.
 * Assumes a packet engine on the same clock that honours the replies it
 * gets, and endpoint type and ping-pong mode supplied from configuration.
 */
`timescale 1ns/1ps
`include "usep_map.svh"
module usep_device (
	// Clock, reset, enable
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Register port
	usep_if.dev bus,
	// Endpoint configuration
	input wire usep_pkg::usep_type_e [5:0] i_ep_type,
	input wire logic [5:0] i_pingpong,
	// Packet engine
	input wire logic [3:0] i_sie_ep,
	input wire logic i_sie_token_valid,
	input wire logic i_sie_token_in,
	input wire logic i_sie_rx_start,
	input wire logic i_sie_rx_setup,
	input wire logic i_sie_rx_valid,
	input wire logic [7:0] i_sie_rx_byte,
	input wire logic i_sie_rx_done,
	input wire logic i_sie_crc_err,
	input wire logic i_sie_tx_pop,
	input wire logic i_sie_in_done,
	input wire logic i_sie_stall_sent,
	// Answers and events
	output logic o_reply_valid,
	output usep_pkg::usep_reply_e o_reply,
	output logic [6:0] o_tx_len,
	output logic [7:0] o_tx_byte,
	output logic [5:0] o_ep_event
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic ep_ok(input logic [3:0] n);
		return n <= `USEP_LAST_EP;
	endfunction

	function automatic logic is_iso(input usep_pkg::usep_type_e t);
		return t == usep_pkg::USEP_ISO;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [3:0] sel_q, sel_d;
	logic [7:0] stat_q [6], stat_d [6];
	logic [7:0] mem_q [6][2][64], mem_d [6][2][64];
	logic [6:0] cnt_q [6][2], cnt_d [6][2];
	logic [6:0] rdp_q [6][2], rdp_d [6][2];
	logic [5:0] wrbank_q, wrbank_d;
	logic [5:0] rdbank_q, rdbank_d;
	logic rxbank_q, rxbank_d;
	logic [7:0] rdata_q, rdata_d;
	logic reply_valid_q, reply_valid_d;
	usep_pkg::usep_reply_e reply_q, reply_d;
	logic [6:0] tx_len_q, tx_len_d;
	logic [7:0] tx_byte_q, tx_byte_d;
	logic [5:0] event_q, event_d;
	logic [2:0] s, e;
	logic sb, tb;
	logic [10:0] cnt_sel;
	logic [7:0] old, nw;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		sel_d = sel_q;
		stat_d = stat_q;
		mem_d = mem_q;
		cnt_d = cnt_q;
		rdp_d = rdp_q;
		wrbank_d = wrbank_q;
		rdbank_d = rdbank_q;
		rxbank_d = rxbank_q;
		rdata_d = 8'h00;
		reply_valid_d = 1'b0;
		reply_d = reply_q;
		tx_len_d = tx_len_q;
		tx_byte_d = tx_byte_q;
		event_d = 6'h00;
		s = sel_q[2:0];
		e = i_sie_ep[2:0];
		sb = 1'b0;
		cnt_sel = 11'h000;
		old = 8'h00;
		nw = 8'h00;
		if (ep_ok(sel_q)) begin
			sb = rdbank_q[s];
			cnt_sel = {4'h0, cnt_q[s][sb]};
		end
		tb = i_sie_rx_setup ? 1'b0 : wrbank_q[e];

		// Firmware reads; status, data and count reads act on the selected endpoint
		if (bus.rd) begin
			case (bus.addr)
				`USEP_OFS_SELECT: rdata_d = {4'h0, sel_q};
				`USEP_OFS_STATUS: rdata_d = ep_ok(sel_q) ? stat_q[s] : 8'h00;
				`USEP_OFS_DATA: begin
					if (ep_ok(sel_q) && rdp_q[s][sb] < cnt_q[s][sb]) begin
						rdata_d = mem_q[s][sb][rdp_q[s][sb][5:0]];
						rdp_d[s][sb] = rdp_q[s][sb] + 7'h01;
					end
				end
				`USEP_OFS_CNT_LO: rdata_d = cnt_sel[7:0];
				`USEP_OFS_CNT_HI: rdata_d = {5'h00, cnt_sel[10:8]};
				default: rdata_d = 8'h00;
			endcase
		end

		// Firmware writes; hardware-set flags clear by writing zero, except the CRC error flag of an iso endpoint, which is kept
		if (bus.wr) begin
			case (bus.addr)
				`USEP_OFS_SELECT: sel_d = bus.wdata[3:0];
				`USEP_OFS_STATUS: begin
					if (ep_ok(sel_q)) begin
						old = stat_q[s];
						nw = old & bus.wdata;
						nw[`USEP_BIT_DIR] = (i_ep_type[s] == usep_pkg::USEP_CONTROL)
							& bus.wdata[`USEP_BIT_DIR];
						nw[`USEP_BIT_STALL] = bus.wdata[`USEP_BIT_STALL];
						nw[`USEP_BIT_READY] = old[`USEP_BIT_READY] | bus.wdata[`USEP_BIT_READY];
						if (is_iso(i_ep_type[s])) begin
							nw[`USEP_BIT_STALL_SENT_OR_CRC_ERROR] = old[`USEP_BIT_STALL_SENT_OR_CRC_ERROR];
						end
						// Freeing a bank hands the other bank to firmware; freeing bank 0 hands over bank 1 only in ping-pong mode
						if (old[`USEP_BIT_B0] && !nw[`USEP_BIT_B0]) begin
							rdp_d[s][0] = 7'h00;
							if (i_pingpong[s]) begin
								rdbank_d[s] = 1'b1;
							end
						end
						if (old[`USEP_BIT_B1] && !nw[`USEP_BIT_B1]) begin
							rdp_d[s][1] = 7'h00;
							rdbank_d[s] = 1'b0;
						end
						stat_d[s] = nw;
					end
				end
				`USEP_OFS_DATA: begin
					if (ep_ok(sel_q) && cnt_q[s][0] < `USEP_DEPTH) begin
						mem_d[s][0][cnt_q[s][0][5:0]] = bus.wdata;
						cnt_d[s][0] = cnt_q[s][0] + 7'h01;
					end
				end
				default: ;
			endcase
		end

		// Packet engine; applied last so a hardware set beats a firmware clear
		if (ep_ok(i_sie_ep)) begin
			if (i_sie_token_valid) begin
				reply_valid_d = 1'b1;
				tx_len_d = cnt_q[e][0];
				if (stat_d[e][`USEP_BIT_STALL]) begin
					reply_d = usep_pkg::USEP_STALL;
				end else if (i_sie_token_in) begin
					rdp_d[e][0] = 7'h00;
					// Ready with nothing loaded gives length zero
					reply_d = stat_d[e][`USEP_BIT_READY] ? usep_pkg::USEP_DATA
						: usep_pkg::USEP_NAK;
				end else if (!is_iso(i_ep_type[e]) && (wrbank_q[e]
						? stat_d[e][`USEP_BIT_B1] : stat_d[e][`USEP_BIT_B0])) begin
					reply_d = usep_pkg::USEP_NAK;
				end else begin
					reply_d = usep_pkg::USEP_ACK;
				end
			end
			if (i_sie_rx_start) begin
				// A SETUP restarts bank 0 even while it is still flagged
				rxbank_d = tb;
				cnt_d[e][tb] = 7'h00;
				rdp_d[e][tb] = 7'h00;
			end
			if (i_sie_rx_valid && cnt_d[e][rxbank_q] < `USEP_DEPTH) begin
				mem_d[e][rxbank_q][cnt_d[e][rxbank_q][5:0]] = i_sie_rx_byte;
				cnt_d[e][rxbank_q] = cnt_d[e][rxbank_q] + 7'h01;
			end
			if (i_sie_rx_done) begin
				event_d[e] = 1'b1;
				if (i_sie_rx_setup) begin
					stat_d[e] = `USEP_STATUS_SETUP_ONLY;
					rdbank_d[e] = 1'b0;
				end else begin
					if (rxbank_q) begin
						stat_d[e][`USEP_BIT_B1] = 1'b1;
					end else begin
						stat_d[e][`USEP_BIT_B0] = 1'b1;
					end
					if (is_iso(i_ep_type[e])) begin
						stat_d[e][`USEP_BIT_STALL_SENT_OR_CRC_ERROR] = i_sie_crc_err;
					end
					if (i_pingpong[e]) begin
						wrbank_d[e] = ~rxbank_q;
					end
				end
			end
			if (i_sie_tx_pop) begin
				tx_byte_d = mem_q[e][0][rdp_d[e][0][5:0]];
				rdp_d[e][0] = rdp_d[e][0] + 7'h01;
			end
			if (i_sie_in_done) begin
				stat_d[e][`USEP_BIT_READY] = 1'b0;
				stat_d[e][`USEP_BIT_CMPL] = 1'b1;
				cnt_d[e][0] = 7'h00;
				rdp_d[e][0] = 7'h00;
				event_d[e] = 1'b1;
			end
			if (i_sie_stall_sent && !is_iso(i_ep_type[e])) begin
				stat_d[e][`USEP_BIT_STALL_SENT_OR_CRC_ERROR] = 1'b1;
				event_d[e] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			sel_q <= `USEP_SELECT_RST;
			stat_q <= '{default: `USEP_STATUS_RST};
			cnt_q <= '{default: 7'h00};
			rdp_q <= '{default: 7'h00};
			wrbank_q <= 6'h00;
			rdbank_q <= 6'h00;
			rxbank_q <= 1'b0;
			rdata_q <= 8'h00;
			reply_valid_q <= 1'b0;
			reply_q <= usep_pkg::USEP_NAK;
			tx_len_q <= 7'h00;
			tx_byte_q <= 8'h00;
			event_q <= 6'h00;
		end else if (i_clk_en) begin
			sel_q <= sel_d;
			stat_q <= stat_d;
			cnt_q <= cnt_d;
			rdp_q <= rdp_d;
			wrbank_q <= wrbank_d;
			rdbank_q <= rdbank_d;
			rxbank_q <= rxbank_d;
			rdata_q <= rdata_d;
			reply_valid_q <= reply_valid_d;
			reply_q <= reply_d;
			tx_len_q <= tx_len_d;
			tx_byte_q <= tx_byte_d;
			event_q <= event_d;
		end
	end

	// Packet data is not reset; its content is undefined until written
	always_ff @(posedge i_clock) begin
		if (i_clk_en) begin
			mem_q <= mem_d;
		end
	end

	assign bus.rdata = rdata_q;
	assign o_reply_valid = reply_valid_q;
	assign o_reply = reply_q;
	assign o_tx_len = tx_len_q;
	assign o_tx_byte = tx_byte_q;
	assign o_ep_event = event_q;

endmodule

// ==== usep_fw.sv ====
/*
 * Firmware end: turns commands into register strobes and keeps the
 * firmware's side of the flag protocol.
 * Assumes the endpoint logic on the same clock answers reads one cycle
 * after the strobe.
 */
`timescale 1ns/1ps
`include "usep_map.svh"
module usep_fw (
	// Clock, reset, enable
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Register port
	usep_if.fw bus,
	// Commands
	input wire logic i_cmd_valid,
	input wire usep_pkg::usep_op_e i_cmd_op,
	input wire logic [7:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_cmd_refused,
	// Responses
	output logic o_rsp_valid,
	output logic [10:0] o_rsp_data
);

	usep_pkg::usep_state_e st_q, st_d;
	logic [7:0] addr_q, addr_d, wdata_q, wdata_d;
	logic wr_q, wr_d, rd_q, rd_d;
	logic ready_q, ready_d, refused_q, refused_d, rsp_valid_q, rsp_valid_d;
	logic [10:0] rsp_q, rsp_d, left_q, left_d;
	logic [7:0] shadow_q, shadow_d;
	logic bad;

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		refused_d = 1'b0;
		rsp_valid_d = 1'b0;
		rsp_d = rsp_q;
		left_d = left_q;
		shadow_d = shadow_q;
		bad = 1'b0;
		case (st_q)
			usep_pkg::USEP_S_IDLE: begin
				if (i_cmd_valid) begin
					wdata_d = i_cmd_data;
					case (i_cmd_op)
						usep_pkg::USEP_OP_SELECT: begin
							addr_d = `USEP_OFS_SELECT;
							wdata_d = {4'h0, i_cmd_data[3:0]};
							wr_d = 1'b1;
						end
						usep_pkg::USEP_OP_STATUS_WR: begin
							// Clears of flags that release FIFO data are refused until it is drained
							bad = (left_q != 11'h000) && (
								(shadow_q[`USEP_BIT_B0] && !i_cmd_data[`USEP_BIT_B0]) ||
								(shadow_q[`USEP_BIT_B1] && !i_cmd_data[`USEP_BIT_B1]) ||
								(shadow_q[`USEP_BIT_SETUP] && !i_cmd_data[`USEP_BIT_SETUP]));
							if (i_cmd_data[`USEP_BIT_READY] && !shadow_q[`USEP_BIT_READY]
								&& i_cmd_data[`USEP_BIT_CMPL] && shadow_q[`USEP_BIT_CMPL]) begin
								bad = 1'b1;
							end
							if (!bad) begin
								addr_d = `USEP_OFS_STATUS;
								wr_d = 1'b1;
								shadow_d = i_cmd_data;
							end
						end
						usep_pkg::USEP_OP_PUSH: begin
							bad = shadow_q[`USEP_BIT_READY];
							if (!bad) begin
								addr_d = `USEP_OFS_DATA;
								wr_d = 1'b1;
							end
						end
						usep_pkg::USEP_OP_STATUS_RD: begin
							addr_d = `USEP_OFS_STATUS;
							rd_d = 1'b1;
							st_d = usep_pkg::USEP_S_RD1;
						end
						usep_pkg::USEP_OP_POP: begin
							addr_d = `USEP_OFS_DATA;
							rd_d = 1'b1;
							if (left_q != 11'h000) begin
								left_d = left_q - 11'h001;
							end
							st_d = usep_pkg::USEP_S_RD1;
						end
						usep_pkg::USEP_OP_COUNT: begin
							addr_d = `USEP_OFS_CNT_LO;
							rd_d = 1'b1;
							st_d = usep_pkg::USEP_S_CNT1;
						end
						default: bad = 1'b1;
					endcase
					refused_d = bad;
				end
			end
			usep_pkg::USEP_S_RD1: st_d = usep_pkg::USEP_S_RD2;
			usep_pkg::USEP_S_RD2: begin
				rsp_d = {3'h0, bus.rdata};
				rsp_valid_d = 1'b1;
				if (addr_q == `USEP_OFS_STATUS) begin
					shadow_d = bus.rdata;
				end
				st_d = usep_pkg::USEP_S_IDLE;
			end
			usep_pkg::USEP_S_CNT1: begin
				addr_d = `USEP_OFS_CNT_HI;
				rd_d = 1'b1;
				st_d = usep_pkg::USEP_S_CNT2;
			end
			usep_pkg::USEP_S_CNT2: begin
				rsp_d = {3'h0, bus.rdata};
				st_d = usep_pkg::USEP_S_CNT3;
			end
			usep_pkg::USEP_S_CNT3: begin
				rsp_d = {bus.rdata[2:0], rsp_q[7:0]};
				left_d = {bus.rdata[2:0], rsp_q[7:0]};
				rsp_valid_d = 1'b1;
				st_d = usep_pkg::USEP_S_IDLE;
			end
			default: st_d = usep_pkg::USEP_S_IDLE;
		endcase
		ready_d = (st_d == usep_pkg::USEP_S_IDLE);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st_q <= usep_pkg::USEP_S_IDLE;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			ready_q <= 1'b0;
			refused_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_q <= 11'h000;
			left_q <= 11'h000;
			shadow_q <= `USEP_STATUS_RST;
		end else if (i_clk_en) begin
			st_q <= st_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			ready_q <= ready_d;
			refused_q <= refused_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_q <= rsp_d;
			left_q <= left_d;
			shadow_q <= shadow_d;
		end
	end

	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign bus.wr = wr_q;
	assign bus.rd = rd_q;
	assign o_cmd_ready = ready_q;
	assign o_cmd_refused = refused_q;
	assign o_rsp_valid = rsp_valid_q;
	assign o_rsp_data = rsp_q;

endmodule

// ==== usep_sva.sv ====
/*
 * Checker for the register port between the firmware end and the endpoint logic.
 * Assumes one clock, a synchronous active-low reset and a clock enable held high.
 */
`timescale 1ns/1ps
`include "usep_map.svh"
module usep_sva (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	// ----------------------------------------
	// Shadow of the endpoint select
	// ----------------------------------------
	logic [3:0] sel_d;
	logic [3:0] sel_q;
	logic ep_rd;
	assign ep_rd = rd && (addr == `USEP_OFS_STATUS || addr == `USEP_OFS_DATA
		|| addr == `USEP_OFS_CNT_LO || addr == `USEP_OFS_CNT_HI);
	always_comb begin
		sel_d = sel_q;
		if (wr && addr == `USEP_OFS_SELECT) begin
			sel_d = wdata[3:0];
		end
	end
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			sel_q <= `USEP_SELECT_RST;
		end else begin
			sel_q <= sel_d;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_one_strobe; !(wr && rd); endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("write and read strobes overlap");
	property p_rdata_idle; !rd |=> rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
	property p_hi_rsvd;
		rd && addr == `USEP_OFS_CNT_HI |=> rdata[7:2] == 6'h00;
	endproperty
	a_hi_rsvd: assert property (p_hi_rsvd) else $error("count high spare bits set");
	property p_cnt_pair;
		rd && addr == `USEP_OFS_CNT_LO |=> rd && addr == `USEP_OFS_CNT_HI;
	endproperty
	a_cnt_pair: assert property (p_cnt_pair) else $error("count halves not paired");
	property p_far_ep;
		ep_rd && sel_q > `USEP_LAST_EP |=> rdata == 8'h00;
	endproperty
	a_far_ep: assert property (p_far_ep) else $error("absent endpoint answered");
	property p_stall_wr;
		wr && addr == `USEP_OFS_STATUS && sel_q <= `USEP_LAST_EP ##2
			rd && addr == `USEP_OFS_STATUS |=>
			rdata[`USEP_BIT_STALL] == $past(wdata[`USEP_BIT_STALL], 3);
	endproperty
	a_stall_wr: assert property (p_stall_wr) else $error("stall request not as written");
	property p_ready_wr;
		wr && addr == `USEP_OFS_STATUS && wdata[`USEP_BIT_READY] && sel_q <= `USEP_LAST_EP ##2
			rd && addr == `USEP_OFS_STATUS |=> rdata[`USEP_BIT_READY];
	endproperty
	a_ready_wr: assert property (p_ready_wr) else $error("ready flag not set");
	property p_sel_rsvd;
		wr && addr == `USEP_OFS_SELECT |-> wdata[7:4] == 4'h0;
	endproperty
	a_sel_rsvd: assert property (p_sel_rsvd) else $error("select spare bits written");
	property p_ro_count;
		wr |-> addr != `USEP_OFS_CNT_LO && addr != `USEP_OFS_CNT_HI;
	endproperty
	a_ro_count: assert property (p_ro_count) else $error("write to byte count");
endmodule

// ==== testbench.sv ====
/*
 * Testbench joining the firmware end and the endpoint logic through the register port.
 * Assumes the package, interface, design modules and checker are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		checks++; \
		if ((g) !== (e)) begin \
			err_total++; \
			$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module testbench;
	localparam usep_pkg::usep_op_e SL = usep_pkg::USEP_OP_SELECT;
	localparam usep_pkg::usep_op_e SW = usep_pkg::USEP_OP_STATUS_WR;
	localparam usep_pkg::usep_op_e ST = usep_pkg::USEP_OP_STATUS_RD;
	localparam usep_pkg::usep_op_e PU = usep_pkg::USEP_OP_PUSH;
	localparam usep_pkg::usep_op_e PO = usep_pkg::USEP_OP_POP;
	localparam usep_pkg::usep_op_e CN = usep_pkg::USEP_OP_COUNT;
	localparam usep_pkg::usep_reply_e ACK = usep_pkg::USEP_ACK;
	localparam usep_pkg::usep_reply_e NAK = usep_pkg::USEP_NAK;
	localparam usep_pkg::usep_reply_e STL = usep_pkg::USEP_STALL;
	localparam usep_pkg::usep_reply_e DAT = usep_pkg::USEP_DATA;
	localparam usep_pkg::usep_type_e [5:0] EP_TYPES = '{usep_pkg::USEP_INTR,
		usep_pkg::USEP_BULK, usep_pkg::USEP_INTR, usep_pkg::USEP_BULK, usep_pkg::USEP_ISO,
		usep_pkg::USEP_CONTROL};
	localparam logic [6:0] M_TOK = 7'h01;
	localparam logic [6:0] M_START = 7'h02;
	localparam logic [6:0] M_BYTE = 7'h04;
	localparam logic [6:0] M_DONE = 7'h08;
	localparam logic [6:0] M_POP = 7'h10;
	localparam logic [6:0] M_IN = 7'h20;
	localparam logic [6:0] M_STALL = 7'h40;
	logic i_clock, i_rst_n, cmd_valid, cmd_ready, cmd_refused, rsp_valid;
	logic tok_in, rx_setup, crc_err, reply_valid;
	usep_pkg::usep_op_e cmd_op;
	usep_pkg::usep_reply_e reply;
	logic [7:0] cmd_data, rx_byte, tx_byte;
	logic [10:0] rsp_data;
	logic [6:0] pulse, tx_len;
	logic [3:0] sie_ep;
	logic [5:0] ep_event;
	int err_total, checks;

	usep_if i_usep_if ();
	usep_fw i_usep_fw (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .bus(i_usep_if),
		.i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_data(cmd_data),
		.o_cmd_ready(cmd_ready), .o_cmd_refused(cmd_refused), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data));
	usep_device i_usep_device (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
		.bus(i_usep_if), .i_ep_type(EP_TYPES), .i_pingpong(6'h10), .i_sie_ep(sie_ep),
		.i_sie_token_valid(pulse[0]), .i_sie_token_in(tok_in), .i_sie_rx_start(pulse[1]),
		.i_sie_rx_setup(rx_setup), .i_sie_rx_valid(pulse[2]), .i_sie_rx_byte(rx_byte),
		.i_sie_rx_done(pulse[3]), .i_sie_crc_err(crc_err), .i_sie_tx_pop(pulse[4]),
		.i_sie_in_done(pulse[5]), .i_sie_stall_sent(pulse[6]), .o_reply_valid(reply_valid),
		.o_reply(reply), .o_tx_len(tx_len), .o_tx_byte(tx_byte), .o_ep_event(ep_event));
	usep_sva i_usep_sva (.i_clock(i_clock), .i_rst_n(i_rst_n), .addr(i_usep_if.addr),
		.wdata(i_usep_if.wdata), .wr(i_usep_if.wr), .rd(i_usep_if.rd), .rdata(i_usep_if.rdata));

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Hold the command until an edge sees ready, so a busy end never loses it
	task automatic issue(input usep_pkg::usep_op_e op, input logic [7:0] d);
		int n = 0;
		@(posedge i_clock);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		do begin
			@(posedge i_clock);
			n++;
		end while (cmd_ready !== 1'b1 && n < 20);
		cmd_valid <= 1'b0;
		if (n >= 20) begin
			`CHK(1'b0, 1'b1)
			complete_run();
		end
	endtask
	task automatic rd_chk(input usep_pkg::usep_op_e op, input logic [10:0] e);
		int n = 0;
		issue(op, 8'h00);
		do begin
			@(posedge i_clock);
			n++;
		end while (rsp_valid !== 1'b1 && n < 20);
		`CHK(rsp_data, e)
		if (n >= 20) begin
			`CHK(1'b0, 1'b1)
			complete_run();
		end
	endtask
	task automatic refused(input logic e);
		@(posedge i_clock);
		`CHK(cmd_refused, e)
	endtask
	task automatic sie(input logic [6:0] m, input logic [3:0] ep, input logic [7:0] b);
		@(posedge i_clock);
		pulse <= m;
		sie_ep <= ep;
		rx_byte <= b;
		@(posedge i_clock);
		pulse <= 7'h00;
	endtask
	task automatic ev(input logic [6:0] m, input logic [3:0] ep);
		sie(m, ep, 8'h00);
		@(posedge i_clock);
		`CHK(ep_event, 6'h01 << ep)
	endtask
	task automatic pkt(input logic [3:0] ep, input int n, input logic [7:0] b);
		sie(M_START, ep, 8'h00);
		for (int i = 0; i < n; i++) begin
			sie(M_BYTE, ep, b + 8'(i));
		end
		ev(M_DONE, ep);
	endtask
	task automatic tok(input logic in, input logic [3:0] ep, input usep_pkg::usep_reply_e e);
		tok_in <= in;
		sie(M_TOK, ep, 8'h00);
		@(posedge i_clock);
		`CHK(reply_valid, 1'b1)
		`CHK(reply, e)
	endtask
	task automatic pop(input logic [3:0] ep, input logic [7:0] e);
		sie(M_POP, ep, 8'h00);
		@(posedge i_clock);
		`CHK(tx_byte, e)
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{cmd_valid, tok_in, rx_setup, crc_err, pulse, sie_ep, rx_byte, cmd_data} = '0;
		cmd_op = SL;
		i_rst_n = 1'b0;
		err_total = 0;
		checks = 0;
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd_chk(CN, 11'h000);
		issue(SL, 8'h02);
		tok(1'b0, 4'h2, ACK);
		pkt(4'h2, 3, 8'ha1);
		rd_chk(ST, 11'h002);
		tok(1'b0, 4'h2, NAK);
		rd_chk(CN, 11'h003);
		for (int i = 0; i < 3; i++) rd_chk(PO, 11'h0a1 + 11'(i));
		issue(SW, 8'h80);
		refused(1'b0);
		rd_chk(ST, 11'h000);
		issue(SL, 8'h03);
		issue(PU, 8'h5a);
		issue(PU, 8'h6b);
		issue(SW, 8'h10);
		rd_chk(ST, 11'h010);
		issue(PU, 8'h77);
		refused(1'b1);
		tok(1'b1, 4'h3, DAT);
		`CHK(tx_len, 7'h02)
		pop(4'h3, 8'h5a);
		pop(4'h3, 8'h6b);
		ev(M_IN, 4'h3);
		rd_chk(ST, 11'h001);
		tok(1'b1, 4'h3, NAK);
		issue(SW, 8'h11);
		refused(1'b1);
		issue(SW, 8'h00);
		issue(SW, 8'h10);
		tok(1'b1, 4'h3, DAT);
		`CHK(tx_len, 7'h00)
		issue(SL, 8'h00);
		issue(SW, 8'h80);
		rd_chk(ST, 11'h080);
		tok(1'b0, 4'h0, ACK);
		pkt(4'h0, 1, 8'h33);
		issue(SW, 8'h22);
		rd_chk(ST, 11'h022);
		tok(1'b0, 4'h0, STL);
		ev(M_STALL, 4'h0);
		rd_chk(ST, 11'h02a);
		rx_setup <= 1'b1;
		pkt(4'h0, 2, 8'hc0);
		rx_setup <= 1'b0;
		rd_chk(ST, 11'h004);
		rd_chk(CN, 11'h002);
		rd_chk(PO, 11'h0c0);
		rd_chk(PO, 11'h0c1);
		issue(SW, 8'h00);
		refused(1'b0);
		issue(SL, 8'h01);
		crc_err <= 1'b1;
		pkt(4'h1, 1, 8'h44);
		rd_chk(ST, 11'h00a);
		tok(1'b0, 4'h1, ACK);
		issue(SW, 8'h00);
		rd_chk(ST, 11'h008);
		crc_err <= 1'b0;
		pkt(4'h1, 1, 8'h45);
		rd_chk(ST, 11'h002);
		issue(SL, 8'h04);
		pkt(4'h4, 1, 8'h11);
		tok(1'b0, 4'h4, ACK);
		pkt(4'h4, 2, 8'h21);
		rd_chk(ST, 11'h042);
		tok(1'b0, 4'h4, NAK);
		rd_chk(CN, 11'h001);
		rd_chk(PO, 11'h011);
		issue(SW, 8'h40);
		refused(1'b0);
		rd_chk(ST, 11'h040);
		rd_chk(CN, 11'h002);
		rd_chk(PO, 11'h021);
		rd_chk(PO, 11'h022);
		pkt(4'h4, 1, 8'h55);
		tok(1'b0, 4'h4, NAK);
		issue(SW, 8'h02);
		rd_chk(CN, 11'h001);
		rd_chk(PO, 11'h055);
		issue(SL, 8'h07);
		rd_chk(ST, 11'h000);
		rd_chk(CN, 11'h000);
		complete_run();
	end
endmodule
